// file: hw/ifs_defs.svh
// Constants for the inverter fault supervisor.
// Assumes a single 100 MHz system clock; included by the synchronizer, hold timer and supervisor files.
`ifndef IFS_DEFS_SVH
`define IFS_DEFS_SVH

// ==========================================================
// Timing
`define IFS_CLK_PERIOD_NS 10
`define IFS_UV_DELAY_NS 250000
`define IFS_UV_CNT_W 16

// ==========================================================
// Comparator vector layout (asynchronous analog inputs)
`define IFS_CMP_W 7
`define IFS_CMP_LAMP_A 0
`define IFS_CMP_LAMP_B 1
`define IFS_CMP_OV 2
`define IFS_CMP_UV 3
`define IFS_CMP_SEC_OC 4
`define IFS_CMP_TIMER 5
`define IFS_CMP_UVLO 6

`endif

// file: hw/ifs_pkg.sv
// Types shared by the inverter fault supervisor.
// Assumes nothing beyond the constants header.
`default_nettype none

package ifs_pkg;
    typedef enum logic [1:0] {
        IFS_SHUTDOWN,
        IFS_RUN,
        IFS_FAULT
    } ifs_state_e;
endpackage

`default_nettype wire

// file: hw/ifs_sync3.sv
// Three-stage synchronizer with agreement filter for asynchronous comparator levels.
// Assumes inputs are quasi-static levels from the analog front end.
`default_nettype none
`include "ifs_defs.svh"

module ifs_sync3 #(
    parameter int WIDTH = `IFS_CMP_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    // ======================================================
    // Filter
    // A change is accepted only when the last two stages agree,
    // so a single metastable sample never reaches the fault logic.
    always_comb begin
        out_next = out_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
                out_next[i] = stage3_reg[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            out_reg <= '0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            out_reg <= out_next;
        end
    end

    assign syncOut = out_reg;
endmodule // ifs_sync3

`default_nettype wire

// file: hw/ifs_hold_timer.sv
// Counts consecutive cycles of a condition and flags when a limit is reached.
// Assumes the condition is already synchronous to clk.
`default_nettype none
`include "ifs_defs.svh"

module ifs_hold_timer #(
    parameter logic [`IFS_UV_CNT_W-1:0] LIMIT = 16'h0001
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cond,
    output logic expired
);
    logic [`IFS_UV_CNT_W-1:0] count_reg;
    logic [`IFS_UV_CNT_W-1:0] count_next;
    logic expired_reg;
    logic expired_next;

    // ======================================================
    // Counter
    // Any gap in the condition restarts the count from zero.
    always_comb begin
        count_next = '0;
        expired_next = 1'b0;
        if (cond) begin
            if (count_reg >= LIMIT - 16'h0001) begin
                count_next = count_reg;
                expired_next = 1'b1;
            end else begin
                count_next = count_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count_reg <= '0;
            expired_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            expired_reg <= expired_next;
        end
    end

    assign expired = expired_reg;
endmodule // ifs_hold_timer

`default_nettype wire

// file: hw/ifs_fault_supervisor.sv
// Fault-protection supervisor for a half-bridge resonant lamp inverter.
// Assumes comparator results arrive as asynchronous levels, and the lamp-enable
// bit, dimming on-period and bridge requests come from logic on clk.
`default_nettype none
`include "ifs_defs.svh"

// Function
// [R1] Lamp current low: 1uA timer charge
// [R2] Timer above 4V: latch fault, shut down
// [R3] Fault shutdown keeps regulator at normal level
// [R4] Clearing lamp-enable or power cycle clears fault
// [R5] Overvoltage switches on compensation discharge sink
// [R6] Switch-node overcurrent: high side off immediately; code trips only while lowSideReq is set
// [R7] Undervoltage 250us during dimming on: shut down
// [R8] Secondary overcurrent: discharge and 135uA timer charge
// [R9] Power-on reset clears fault and registers
// [R10] Undervoltage lockout disables both gate drivers
// [R11] Lamp-enable cleared: low-power shutdown, regulator only
// [R12] Fault latch held reset during shutdown
// [R13] Lamp-enable set: leave shutdown, resume
// [R14] Overvoltage discharge limits peak during lamp-out
// [R15] Enable starts fast, disable stops at once
// [R16] Serial interface stays alive in shutdown
// [R17] Discharge enable is OR of both requests
// [R18] Both conditions select the larger charge
module ifs_fault_supervisor
    import ifs_pkg::*;
#(
    parameter logic [`IFS_UV_CNT_W-1:0] UV_DELAY_CYCLES =
        `IFS_UV_CNT_W'(`IFS_UV_DELAY_NS / `IFS_CLK_PERIOD_NS)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic lampLowA,
    input wire logic lampLowB,
    input wire logic secOverVolt,
    input wire logic secUnderVolt,
    input wire logic secOverCurr,
    input wire logic timerTrip,
    input wire logic vccBelowUvlo,
    input wire logic switchNodeOverCurr,
    input wire logic lampEnableBit,
    input wire logic burstDimmingOn,
    input wire logic highSideReq,
    input wire logic lowSideReq,
    output logic highSideGate,
    output logic lowSideGate,
    output logic compDischargeEn,
    output logic timerChargeLowEn,
    output logic timerChargeHighEn,
    output logic timerCapClear,
    output logic faultLatched,
    output logic underVoltShutdown,
    output logic regulatorLowPower,
    output logic serialIfEnable,
    output logic inverterActive
);
    import ifs_pkg::*;

    // ======================================================
    // Input synchronization
    logic [`IFS_CMP_W-1:0] cmpRaw;
    logic [`IFS_CMP_W-1:0] cmpSync;
    logic lampOut;
    logic overVolt;
    logic overCurr;
    logic timerHigh;
    logic uvlo;
    logic uvExpired;

    assign cmpRaw[`IFS_CMP_LAMP_A] = lampLowA;
    assign cmpRaw[`IFS_CMP_LAMP_B] = lampLowB;
    assign cmpRaw[`IFS_CMP_OV] = secOverVolt;
    assign cmpRaw[`IFS_CMP_UV] = secUnderVolt;
    assign cmpRaw[`IFS_CMP_SEC_OC] = secOverCurr;
    assign cmpRaw[`IFS_CMP_TIMER] = timerTrip;
    assign cmpRaw[`IFS_CMP_UVLO] = vccBelowUvlo;

    ifs_sync3 #(
        .WIDTH(`IFS_CMP_W)
    ) u_cmp_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(cmpRaw),
        .syncOut(cmpSync)
    );

    // The current-limit comparator is fast; it gets its own chain so the
    // cut-off path does not wait behind the slower fault comparators.
    logic [0:0] ocRaw;
    logic [0:0] ocSync;

    assign ocRaw[0] = switchNodeOverCurr;

    ifs_sync3 #(
        .WIDTH(1)
    ) u_oc_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(ocRaw),
        .syncOut(ocSync)
    );

    // [R1] Either lamp low
    assign lampOut = cmpSync[`IFS_CMP_LAMP_A] | cmpSync[`IFS_CMP_LAMP_B];
    assign overVolt = cmpSync[`IFS_CMP_OV];
    assign overCurr = cmpSync[`IFS_CMP_SEC_OC];
    assign timerHigh = cmpSync[`IFS_CMP_TIMER];
    assign uvlo = cmpSync[`IFS_CMP_UVLO];

    // ======================================================
    // Secondary undervoltage delay
    ifs_state_e state_reg;
    ifs_state_e state_next;
    logic uvWatch;

    // [R7] Continuous undervoltage window
    assign uvWatch = (state_reg == IFS_RUN) & burstDimmingOn & cmpSync[`IFS_CMP_UV];

    ifs_hold_timer #(
        .LIMIT(UV_DELAY_CYCLES)
    ) u_uv_timer (
        .clk(clk),
        .rst_b(rst_b),
        .cond(uvWatch),
        .expired(uvExpired)
    );

    // ======================================================
    // Operating state
    logic uvShut_reg;
    logic uvShut_next;

    always_comb begin
        state_next = state_reg;
        uvShut_next = uvShut_reg;
        case (state_reg)
            IFS_SHUTDOWN: begin
                // [R12] Fault held reset
                uvShut_next = 1'b0;
                // [R13] Re-enable on set
                if (lampEnableBit) begin
                    // [R15] Start without delay
                    state_next = IFS_RUN;
                end
            end
            IFS_RUN: begin
                if (!lampEnableBit) begin
                    // [R11] Enter low-power shutdown
                    state_next = IFS_SHUTDOWN;
                end else if (timerHigh) begin
                    // [R2] Timer trip latches
                    state_next = IFS_FAULT;
                end else if (uvExpired) begin
                    // [R7] Undervoltage shutdown
                    state_next = IFS_FAULT;
                    uvShut_next = 1'b1;
                end
            end
            IFS_FAULT: begin
                // [R4] Clear by lamp-enable low
                if (!lampEnableBit) begin
                    state_next = IFS_SHUTDOWN;
                    uvShut_next = 1'b0;
                end
            end
            default: begin
                state_next = IFS_SHUTDOWN;
                uvShut_next = 1'b0;
            end
        endcase
    end

    // [R9] Power-on reset clears all
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= IFS_SHUTDOWN;
            uvShut_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            uvShut_reg <= uvShut_next;
        end
    end

    // ======================================================
    // Primary overcurrent blanking
    // Once tripped, the high side stays off until the bridge logic starts
    // a fresh high-side pulse; re-arming mid-pulse would let current climb.
    logic ocBlock_reg;
    logic ocBlock_next;
    logic hsReqDly_reg;
    logic hsReqDly_next;

    always_comb begin
        ocBlock_next = ocBlock_reg;
        hsReqDly_next = highSideReq;
        if (lowSideReq && ocSync[0]) begin
            // [R6] Trip during low-side on
            ocBlock_next = 1'b1;
        end else if (highSideReq && !hsReqDly_reg) begin
            ocBlock_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ocBlock_reg <= 1'b0;
            hsReqDly_reg <= 1'b0;
        end else begin
            ocBlock_reg <= ocBlock_next;
            hsReqDly_reg <= hsReqDly_next;
        end
    end

    // ======================================================
    // Output stage
    logic hsGate_reg;
    logic hsGate_next;
    logic lsGate_reg;
    logic lsGate_next;
    logic compDis_reg;
    logic compDis_next;
    logic chgLow_reg;
    logic chgLow_next;
    logic chgHigh_reg;
    logic chgHigh_next;
    logic capClr_reg;
    logic capClr_next;
    logic fault_reg;
    logic fault_next;
    logic uvOut_reg;
    logic uvOut_next;
    logic regLow_reg;
    logic regLow_next;
    logic serial_reg;
    logic serial_next;
    logic active_reg;
    logic active_next;
    logic running;

    // Outputs follow the next state so a disable stops the bridge one cycle sooner.
    assign running = (state_next == IFS_RUN);

    always_comb begin
        // [R10] Lockout gates both drivers
        hsGate_next = running & !uvlo & highSideReq & !ocBlock_next;
        lsGate_next = running & !uvlo & lowSideReq;
        // [R17] OR of both requests
        // [R5] Overvoltage discharge sink
        // [R14] Peak limited during delay
        // [R8] Overcurrent discharge too
        compDis_next = running & (overVolt | overCurr);
        // [R8] Heavy timer charge
        chgHigh_next = running & overCurr;
        // [R18] Larger current wins
        // [R1] Lamp-out timer charge
        chgLow_next = running & lampOut & !overCurr;
        // Timer is held empty in shutdown so a new start gets a full delay.
        capClr_next = !running & (state_next != IFS_FAULT);
        fault_next = (state_next == IFS_FAULT);
        uvOut_next = uvShut_next;
        // [R3] Fault keeps regulator normal
        // [R11] Shutdown lowers regulator
        regLow_next = (state_next == IFS_SHUTDOWN);
        // [R16] Serial side never gated
        serial_next = 1'b1;
        active_next = running;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hsGate_reg <= 1'b0;
            lsGate_reg <= 1'b0;
            compDis_reg <= 1'b0;
            chgLow_reg <= 1'b0;
            chgHigh_reg <= 1'b0;
            capClr_reg <= 1'b1;
            fault_reg <= 1'b0;
            uvOut_reg <= 1'b0;
            regLow_reg <= 1'b1;
            serial_reg <= 1'b1;
            active_reg <= 1'b0;
        end else begin
            hsGate_reg <= hsGate_next;
            lsGate_reg <= lsGate_next;
            compDis_reg <= compDis_next;
            chgLow_reg <= chgLow_next;
            chgHigh_reg <= chgHigh_next;
            capClr_reg <= capClr_next;
            fault_reg <= fault_next;
            uvOut_reg <= uvOut_next;
            regLow_reg <= regLow_next;
            serial_reg <= serial_next;
            active_reg <= active_next;
        end
    end

    assign highSideGate = hsGate_reg;
    assign lowSideGate = lsGate_reg;
    assign compDischargeEn = compDis_reg;
    assign timerChargeLowEn = chgLow_reg;
    assign timerChargeHighEn = chgHigh_reg;
    assign timerCapClear = capClr_reg;
    assign faultLatched = fault_reg;
    assign underVoltShutdown = uvOut_reg;
    assign regulatorLowPower = regLow_reg;
    assign serialIfEnable = serial_reg;
    assign inverterActive = active_reg;
endmodule // ifs_fault_supervisor

`default_nettype wire

// file: tb/ifs_sup_checker.sv
// Port assertions for the inverter fault supervisor.
// Assumes one clock and the synchronous active-low reset.
`default_nettype none

module ifs_sup_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic lampLowA,
    input wire logic secOverVolt,
    input wire logic secOverCurr,
    input wire logic timerTrip,
    input wire logic vccBelowUvlo,
    input wire logic switchNodeOverCurr,
    input wire logic lampEnableBit,
    input wire logic highSideReq,
    input wire logic lowSideReq,
    input wire logic highSideGate,
    input wire logic lowSideGate,
    input wire logic compDischargeEn,
    input wire logic timerChargeLowEn,
    input wire logic timerChargeHighEn,
    input wire logic faultLatched,
    input wire logic regulatorLowPower,
    input wire logic serialIfEnable,
    input wire logic inverterActive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Held conditions: seven samples cover the five-edge comparator path
    sequence ovHeld_s;
        (secOverVolt && inverterActive) [*7];
    endsequence
    sequence shortHeld_s;
        (secOverCurr && inverterActive) [*7];
    endsequence
    sequence lampOutHeld_s;
        (lampLowA && !secOverCurr && inverterActive) [*7];
    endsequence

    // ==========================================================
    // Shutdown, fault and lockout
    serial_alive_a: assert property (serialIfEnable)
        else $error("serial interface disabled");
    quiet_off_a: assert property (
        !inverterActive |-> !highSideGate && !lowSideGate && !compDischargeEn)
        else $error("drive active while stopped");
    low_power_a: assert property (
        !lampEnableBit |=> regulatorLowPower && !faultLatched)
        else $error("shutdown not entered");
    fault_reg_a: assert property (
        faultLatched |-> !regulatorLowPower && !inverterActive)
        else $error("fault state wrong");
    enter_run_a: assert property ($rose(lampEnableBit) |=> inverterActive)
        else $error("run not entered");
    trip_latch_a: assert property ((timerTrip && lampEnableBit) [*7] |-> faultLatched)
        else $error("trip not latched");
    uvlo_gates_a: assert property (vccBelowUvlo [*6] |-> !highSideGate && !lowSideGate)
        else $error("gates on in lockout");
    hs_block_a: assert property (
        (switchNodeOverCurr && lowSideReq && highSideReq && inverterActive) [*7]
        |-> !highSideGate)
        else $error("high side not cut");

    // ==========================================================
    // Discharge and timer charge
    ov_sink_a: assert property (ovHeld_s |-> compDischargeEn)
        else $error("no discharge on overvoltage");
    short_chg_a: assert property (
        shortHeld_s |-> timerChargeHighEn && !timerChargeLowEn && compDischargeEn)
        else $error("short response wrong");
    lamp_chg_a: assert property (lampOutHeld_s |-> timerChargeLowEn)
        else $error("no low timer charge");
endmodule // ifs_sup_checker

bind ifs_fault_supervisor ifs_sup_checker chkI (.clk, .rst_b, .lampLowA, .secOverVolt,
    .secOverCurr, .timerTrip, .vccBelowUvlo, .switchNodeOverCurr, .lampEnableBit,
    .highSideReq, .lowSideReq, .highSideGate, .lowSideGate, .compDischargeEn,
    .timerChargeLowEn, .timerChargeHighEn, .faultLatched, .regulatorLowPower,
    .serialIfEnable, .inverterActive);

`default_nettype wire

// file: tb/ifs_front_end_model.sv
// Behavioural lamp sense and fault-timer capacitor.
// Assumes charge enables from the supervisor; one unit per uA per cycle.
`default_nettype none

module ifs_front_end_model #(
    parameter int TRIP_LEVEL = 300
) (
    input wire logic clk,
    input wire logic [1:0] lampOpen,
    input wire logic timerChargeLowEn,
    input wire logic timerChargeHighEn,
    input wire logic timerCapClear,
    output logic lampLowA,
    output logic lampLowB,
    output logic timerTrip
);
    int capLevel = 0;

    // An open lamp carries no current at all
    assign lampLowA = lampOpen[0];
    assign lampLowB = lampOpen[1];

    always @(posedge clk) begin
        if (timerCapClear) begin
            capLevel <= 0;
        end else begin
            capLevel <= capLevel + (timerChargeHighEn ? 135 : 0) + (timerChargeLowEn ? 1 : 0);
        end
    end
    assign timerTrip = capLevel > TRIP_LEVEL;
endmodule // ifs_front_end_model

`default_nettype wire

// file: tb/tb_inverter_fault_supervisor.sv
// Self-checking bench for the inverter fault supervisor.
// Assumes the front-end model and the bound checker.
`default_nettype none

module tb_inverter_fault_supervisor;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 0, rst_b = 0, secOverVolt = 0, secUnderVolt = 0, secOverCurr = 0;
    logic vccBelowUvlo = 0, switchNodeOverCurr = 0, lampEnableBit = 0;
    logic burstDimmingOn = 0, highSideReq = 0, lowSideReq = 0;
    logic [1:0] lampOpen = 2'h0;
    logic lampLowA, lampLowB, timerTrip, highSideGate, lowSideGate, compDischargeEn;
    logic timerChargeLowEn, timerChargeHighEn, timerCapClear, faultLatched;
    logic underVoltShutdown, regulatorLowPower, serialIfEnable, inverterActive;
    int badCount = 0, nChecks = 0;

    always #5 clk = ~clk;

    ifs_front_end_model fe (.clk, .lampOpen, .timerChargeLowEn, .timerChargeHighEn,
        .timerCapClear, .lampLowA, .lampLowB, .timerTrip);

    // Short undervoltage delay keeps the run brief
    ifs_fault_supervisor #(.UV_DELAY_CYCLES(16'h0008)) dut (.clk, .rst_b, .lampLowA,
        .lampLowB, .secOverVolt, .secUnderVolt, .secOverCurr, .timerTrip, .vccBelowUvlo,
        .switchNodeOverCurr, .lampEnableBit, .burstDimmingOn, .highSideReq, .lowSideReq,
        .highSideGate, .lowSideGate, .compDischargeEn, .timerChargeLowEn,
        .timerChargeHighEn, .timerCapClear, .faultLatched, .underVoltShutdown,
        .regulatorLowPower, .serialIfEnable, .inverterActive);

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic seen, input logic exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic waitFault(input int limit);
        for (int i = 0; i < limit && faultLatched !== 1'h1; i++) step(1);
        chk("faultLatched", faultLatched, 1'h1);
    endtask

    // Clears a fault, lets the synchronizers settle, then restarts
    task automatic reEnable();
        lampEnableBit = 0;
        step(1);
        chk("faultLatched", faultLatched, 1'h0);
        chk("regulatorLowPower", regulatorLowPower, 1'h1);
        step(8);
        lampEnableBit = 1;
        step(1);
        chk("inverterActive", inverterActive, 1'h1);
    endtask

    task automatic completeRun();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic testEnable();
        lampEnableBit = 1;
        highSideReq = 1;
        step(1);
        chk("regulatorLowPower", regulatorLowPower, 1'h0);
        chk("highSideGate", highSideGate, 1'h1);
        chk("timerCapClear", timerCapClear, 1'h0);
    endtask

    task automatic testSwitchOc();
        lowSideReq = 1;
        switchNodeOverCurr = 1;
        step(8);
        chk("highSideGate", highSideGate, 1'h0);
        chk("lowSideGate", lowSideGate, 1'h1);
        switchNodeOverCurr = 0;
        lowSideReq = 0;
        highSideReq = 0;
        step(7);
        highSideReq = 1;
        step(1);
        chk("highSideGate", highSideGate, 1'h1);
    endtask

    task automatic testOv();
        secOverVolt = 1;
        step(8);
        chk("compDischargeEn", compDischargeEn, 1'h1);
        secOverVolt = 0;
        step(8);
        chk("compDischargeEn", compDischargeEn, 1'h0);
    endtask

    task automatic testLampOut(input logic [1:0] which);
        lampOpen = which;
        step(8);
        chk("timerChargeLowEn", timerChargeLowEn, 1'h1);
        secOverVolt = 1;
        step(6);
        chk("compDischargeEn", compDischargeEn, 1'h1);
        secOverVolt = 0;
        waitFault(400);
        chk("regulatorLowPower", regulatorLowPower, 1'h0);
        chk("highSideGate", highSideGate, 1'h0);
        step(3);
        chk("faultLatched", faultLatched, 1'h1);
        lampOpen = 2'h0;
        reEnable();
    endtask

    task automatic testShort();
        lampOpen = 2'h1;
        secOverCurr = 1;
        step(6);
        chk("timerChargeHighEn", timerChargeHighEn, 1'h1);
        chk("timerChargeLowEn", timerChargeLowEn, 1'h0);
        chk("compDischargeEn", compDischargeEn, 1'h1);
        waitFault(20);
        lampOpen = 2'h0;
        secOverCurr = 0;
        reEnable();
    endtask

    task automatic testUnderVolt();
        secUnderVolt = 1;
        step(20);
        chk("faultLatched", faultLatched, 1'h0);
        burstDimmingOn = 1;
        waitFault(20);
        chk("underVoltShutdown", underVoltShutdown, 1'h1);
        secUnderVolt = 0;
        burstDimmingOn = 0;
        reEnable();
    endtask

    task automatic testUvlo();
        vccBelowUvlo = 1;
        lowSideReq = 1;
        step(6);
        chk("highSideGate", highSideGate, 1'h0);
        chk("lowSideGate", lowSideGate, 1'h0);
        chk("inverterActive", inverterActive, 1'h1);
        vccBelowUvlo = 0;
        step(6);
        chk("highSideGate", highSideGate, 1'h1);
        chk("lowSideGate", lowSideGate, 1'h1);
        lowSideReq = 0;
    endtask

    task automatic testPor();
        secOverCurr = 1;
        waitFault(20);
        secOverCurr = 0;
        rst_b = 0;
        step(4);
        chk("faultLatched", faultLatched, 1'h0);
        chk("serialIfEnable", serialIfEnable, 1'h1);
        // Enable is still set, so the first edge after release restarts the lamp
        rst_b = 1;
        step(2);
        chk("inverterActive", inverterActive, 1'h1);
        chk("faultLatched", faultLatched, 1'h0);
    endtask

    initial begin
        #100us;
        badCount++;
        completeRun();
    end

    initial begin
        step(10);
        rst_b = 1;
        step(1);
        chk("regulatorLowPower", regulatorLowPower, 1'h1);
        chk("inverterActive", inverterActive, 1'h0);
        testEnable();
        testSwitchOc();
        testOv();
        testLampOut(2'h1);
        testLampOut(2'h2);
        testShort();
        testUnderVolt();
        testUvlo();
        testPor();
        completeRun();
    end
endmodule // tb_inverter_fault_supervisor

`default_nettype wire
